// >>> common/pxb_pkg.sv
// Constants and types for the port crossbar and output mode block.
// Assumes one system clock, synchronous active-high reset, 8-bit register port.
//
// Behaviour
// [R1] Skip bits 6..0 make crossbar pass pins
// [R2] Array count field routes zero to three outputs
// [R3] Async comparator enable routes unclocked comparator output
// [R4] Sync comparator enable routes clocked comparator output
// [R5] Sysclock enable drives system clock onto pin
// [R6] Two-wire enable routes data and clock pins
// [R7] Receive enable takes receive input from pin 5
// [R8] Transmit enable drives transmit onto pin 4
// [R9] Drive bit: 1 push-pull, 0 open-drain
// [R10] Drive bit ignored while pin is analog
// [R11] Two-wire pins always open-drain
// [R12] Priority assignment lowest pin first; skip bit7 zero
package pxb_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] PORT_OUTPUT_DRIVE_SELECT_ADDR   = 8'hA4;
   localparam logic [7:0] CROSSBAR_PIN_SKIP_ADDR          = 8'hE1;
   localparam logic [7:0] CROSSBAR_PERIPHERAL_ENABLE_ADDR = 8'hE2;
   localparam logic [7:0] PORT_PIN_LEVEL_ADDR             = 8'hF0;
   localparam logic [7:0] PORT_INPUT_MODE_SELECT_ADDR     = 8'hF1;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] DRIVE_SELECT_RESET = 8'h00;
   localparam logic [6:0] PIN_SKIP_RESET     = 7'h00;
   localparam logic [7:0] PERIPH_EN_RESET    = 8'h00;
   localparam logic [7:0] INPUT_MODE_RESET   = 8'hFF;
   localparam logic [7:0] PIN_SYNC_RESET     = 8'hFF;
   localparam logic [7:0] READ_IDLE          = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Peripheral enable field positions and fixed serial pin numbers
   localparam int SERIAL_TX_PIN_ENABLE_BIT        = 0;
   localparam int SERIAL_RX_PIN_ENABLE_BIT        = 1;
   localparam int TWO_WIRE_PINS_ENABLE_BIT        = 2;
   localparam int SYSCLOCK_OUT_ENABLE_BIT         = 3;
   localparam int SYNC_COMPARATOR_OUT_ENABLE_BIT  = 4;
   localparam int ASYNC_COMPARATOR_OUT_ENABLE_BIT = 5;
   localparam int ARRAY_OUTPUT_COUNT_LSB          = 6;
   localparam int TX_PIN                          = 4;
   localparam int RX_PIN                          = 5;

   ////////////////////////////////////////////////////////////////////////////
   // Pin function selection
   typedef enum logic [3:0] {
      SEL_NONE   = 4'h0,
      SEL_TX     = 4'h1,
      SEL_RX     = 4'h2,
      SEL_SDA    = 4'h3,
      SEL_SCL    = 4'h4,
      SEL_CMPS   = 4'h5,
      SEL_CMPA   = 4'h6,
      SEL_SYSCLK = 4'h7,
      SEL_ARR0   = 4'h8,
      SEL_ARR1   = 4'h9,
      SEL_ARR2   = 4'hA
   } pxb_sel_t;

   typedef pxb_sel_t [7:0] pxb_map_t;

   // Crossbar priority of the movable signals, highest first
   localparam pxb_sel_t PRIORITY_ORDER [0:7] = '{SEL_SDA, SEL_SCL, SEL_CMPS, SEL_CMPA,
                                                SEL_SYSCLK, SEL_ARR0, SEL_ARR1, SEL_ARR2};

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wrData;
      logic       wr;
      logic       rd;
   } pxb_bus_req_t;

   typedef struct packed {
      logic       tx;
      logic       sda;
      logic       scl;
      logic       cmpSync;
      logic       cmpAsync;
      logic [2:0] arrayOut;
   } pxb_periph_out_t;

   typedef struct packed {
      logic rx;
      logic sda;
      logic scl;
   } pxb_periph_in_t;

endpackage : pxb_pkg

// >>> dv/pxb_port_crossbar_tb.sv
// Self-checking bench for the port crossbar and output mode block.
// Assumes the design package is compiled first; one clock, bench drives all ports.
`timescale 1ns/1ps

module pxb_port_crossbar_tb;
   logic                     mclk;
   logic                     sys_rst;
   logic                     clkEn;
   pxb_pkg::pxb_bus_req_t    busReq;
   logic [7:0]               rdData;
   pxb_pkg::pxb_periph_out_t periphOut;
   pxb_pkg::pxb_periph_in_t  periphIn;
   logic [7:0]               pinIn;
   logic [7:0]               pinOut;
   logic [7:0]               pinOe;
   int                       fail_count;
   int                       tests_run;

   pxb_port_crossbar pxb_port_crossbar_inst
   (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .clkEn     (clkEn),
      .busReq    (busReq),
      .rdData    (rdData),
      .periphOut (periphOut),
      .periphIn  (periphIn),
      .pinIn     (pinIn),
      .pinOut    (pinOut),
      .pinOe     (pinOe)
   );

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      busReq.addr   <= a;
      busReq.wrData <= d;
      busReq.wr     <= 1'b1;
      @(posedge mclk);
      busReq.wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      busReq.addr <= a;
      busReq.rd   <= 1'b1;
      @(posedge mclk);
      busReq.rd <= 1'b0;
      #1;
      chk("rdData", exp, rdData);
   endtask : rd

   task automatic tick(input int c);
      repeat (c) @(posedge mclk);
      #1;
   endtask : tick

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("pinOe", 8'h00, pinOe);
      chk("periphIn", 8'h07, {5'h00, periphIn});
      rd(8'hA4, 8'h00);
      rd(8'hE1, 8'h00);
      rd(8'hE2, 8'h00);
      rd(8'hF1, 8'hFF);
      rd(8'hF0, 8'hFF);
      tick(1);
      chk("rdData idle", 8'h00, rdData);
      rd(8'h10, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_skip();
      wr(8'hE1, 8'hFF);
      rd(8'hE1, 8'h7F);
      wr(8'hE1, 8'h00);
      wr(8'hF0, 8'h00);
      rd(8'hF0, 8'hFF);
      @(posedge mclk);
      clkEn <= 1'b0;
      wr(8'hE2, 8'h01);
      @(posedge mclk);
      clkEn <= 1'b1;
      tick(1);
      chk("pinOe", 8'h00, pinOe);
      $display("test skip done");
   endtask : t_skip

   task automatic t_tx();
      wr(8'hE2, 8'h01);
      chk("pinOe", 8'h10, pinOe);
      chk("pinOut4", 8'h00, {7'h00, pinOut[4]});
      @(posedge mclk);
      periphOut.tx <= 1'b1;
      #1;
      chk("pinOe", 8'h00, pinOe);
      wr(8'hA4, 8'h10);
      chk("pinOe", 8'h10, pinOe);
      chk("pinOut4", 8'h01, {7'h00, pinOut[4]});
      wr(8'hF1, 8'hEF);
      chk("pinOe", 8'h00, pinOe);
      wr(8'hF1, 8'hFF);
      wr(8'hE2, 8'h00);
      chk("pinOe", 8'h00, pinOe);
      $display("test tx done");
   endtask : t_tx

   task automatic t_rx();
      @(posedge mclk);
      pinIn <= 8'hDF;
      wr(8'hE2, 8'h02);
      tick(2);
      chk("rx", 8'h00, {7'h00, periphIn.rx});
      chk("pinOe", 8'h00, pinOe);
      rd(8'hF0, 8'hDF);
      wr(8'hE2, 8'h00);
      chk("rx", 8'h01, {7'h00, periphIn.rx});
      @(posedge mclk);
      pinIn <= 8'hFF;
      $display("test rx done");
   endtask : t_rx

   task automatic t_cmp();
      wr(8'hA4, 8'hFF);
      wr(8'hE2, 8'h10);
      chk("pinOe sync", 8'h01, pinOe);
      wr(8'hE2, 8'h20);
      chk("pinOe async", 8'h01, pinOe);
      wr(8'hE2, 8'h08);
      chk("pinOe sysclk", 8'h01, pinOe);
      wr(8'hE2, 8'h38);
      chk("pinOe", 8'h07, pinOe);
      chk("sysclk high", 8'h01, {7'h00, pinOut[2]});
      #13;
      chk("sysclk low", 8'h00, {7'h00, pinOut[2]});
      @(posedge mclk);
      periphOut.cmpAsync <= 1'b1;
      periphOut.cmpSync  <= 1'b1;
      #1;
      chk("async", 8'h01, {7'h00, pinOut[1]});
      tick(1);
      chk("sync early", 8'h00, {7'h00, pinOut[0]});
      tick(1);
      chk("sync", 8'h01, {7'h00, pinOut[0]});
      wr(8'hE2, 8'h00);
      chk("pinOe", 8'h00, pinOe);
      $display("test comparator done");
   endtask : t_cmp

   task automatic t_prio();
      wr(8'hE1, 8'h03);
      @(posedge mclk);
      periphOut.arrayOut <= 3'h7;
      for (int n = 0; n < 4; n++)
      begin
         wr(8'hE2, 8'(n << 6));
         chk("array pinOe", 8'(((1 << n) - 1) << 2), pinOe);
      end
      @(posedge mclk);
      periphOut.arrayOut <= 3'h5;
      periphOut.sda      <= 1'b0;
      periphOut.scl      <= 1'b1;
      pinIn              <= 8'hF7;
      wr(8'hE2, 8'hC4);
      chk("pinOe", 8'h74, pinOe);
      chk("pinOut", 8'h50, {1'b0, pinOut[6:4], 1'b0, pinOut[2], 2'h0});
      tick(2);
      chk("scl in", 8'h00, {7'h00, periphIn.scl});
      chk("sda in", 8'h01, {7'h00, periphIn.sda});
      wr(8'hE2, 8'h00);
      chk("pinOe", 8'h00, pinOe);
      $display("test priority done");
   endtask : t_prio

   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   initial
   begin
      fail_count = 0;
      tests_run  = 0;
      sys_rst    = 1'b1;
      clkEn      = 1'b1;
      busReq     = '0;
      periphOut  = '0;
      pinIn      = 8'hFF;
      repeat (12) @(posedge mclk);
      sys_rst <= 1'b0;
      tick(1);
      t_reset();
      t_skip();
      t_tx();
      t_rx();
      t_cmp();
      t_prio();
      final_report();
   end

   // Cuts a hang well past the expected hundred or so cycles
   initial
   begin
      #(3000 * 25);
      fail_count++;
      final_report();
   end
endmodule : pxb_port_crossbar_tb

// >>> hw/pxb_port_crossbar.sv
// Port crossbar: routes peripheral signals onto 8 port pins and sets pin drive mode.
// Assumes peripheral outputs on mclk except the unclocked comparator output;
// pin inputs and the clocked comparator output arrive asynchronously.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps

module pxb_port_crossbar
(
   input  wire logic                     mclk,
   input  wire logic                     sys_rst,
   input  wire logic                     clkEn,
   input  wire pxb_pkg::pxb_bus_req_t    busReq,
   output logic [7:0]                    rdData,
   input  wire pxb_pkg::pxb_periph_out_t periphOut,
   output pxb_pkg::pxb_periph_in_t       periphIn,
   input  wire logic [7:0]               pinIn,
   output logic [7:0]                    pinOut,
   output logic [7:0]                    pinOe
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [7:0] drvSel;
      logic [6:0] skip;
      logic [7:0] perEn;
      logic [7:0] inMode;
      logic [7:0] rdData;
      logic [7:0] pinMeta;
      logic [7:0] pinSync;
      logic       cmpMeta;
      logic       cmpSync;
   } pxb_xbar_state_t;

   pxb_xbar_state_t st;
   pxb_xbar_state_t next_st;
   pxb_pkg::pxb_map_t pinMap;
   logic [7:0]        pinVal;
   logic [7:0]        pinOd;
   logic [7:0]        pinDrive;

   ////////////////////////////////////////////////////////////////////////////
   // Crossbar decode

   function automatic pxb_pkg::pxb_map_t crossbar_map
   (
      input logic [6:0] skip,
      input logic [7:0] en
   );
      pxb_pkg::pxb_map_t m;
      logic [7:0]        used;
      logic [7:0]        req;
      logic              done;
      logic [1:0]        cnt;
      m    = '{default: pxb_pkg::SEL_NONE};
      used = {1'b0, skip};
      cnt  = en[pxb_pkg::ARRAY_OUTPUT_COUNT_LSB +: 2];
      if (en[pxb_pkg::SERIAL_TX_PIN_ENABLE_BIT])
      begin
         m[pxb_pkg::TX_PIN]    = pxb_pkg::SEL_TX;
         used[pxb_pkg::TX_PIN] = 1'b1;
      end
      if (en[pxb_pkg::SERIAL_RX_PIN_ENABLE_BIT])
      begin
         m[pxb_pkg::RX_PIN]    = pxb_pkg::SEL_RX;
         used[pxb_pkg::RX_PIN] = 1'b1;
      end
      req[0] = en[pxb_pkg::TWO_WIRE_PINS_ENABLE_BIT];
      req[1] = en[pxb_pkg::TWO_WIRE_PINS_ENABLE_BIT];
      req[2] = en[pxb_pkg::SYNC_COMPARATOR_OUT_ENABLE_BIT];
      req[3] = en[pxb_pkg::ASYNC_COMPARATOR_OUT_ENABLE_BIT];
      req[4] = en[pxb_pkg::SYSCLOCK_OUT_ENABLE_BIT];
      req[5] = (cnt >= 2'h1);                             // [R2]
      req[6] = (cnt >= 2'h2);                             // [R2]
      req[7] = (cnt == 2'h3);                             // [R2]
      // Each requested signal takes the lowest free, non-skipped pin
      for (int s = 0; s < 8; s++)
      begin
         done = !req[s];
         for (int p = 0; p < 8; p++)
         begin
            if (!done && !used[p])                        // [R1] [R12]
            begin
               m[p]    = pxb_pkg::PRIORITY_ORDER[s];
               used[p] = 1'b1;
               done    = 1'b1;
            end
         end
      end
      return m;
   endfunction : crossbar_map

   function automatic logic is_two_wire
   (
      input pxb_pkg::pxb_sel_t sel
   );
      return (sel == pxb_pkg::SEL_SDA) || (sel == pxb_pkg::SEL_SCL);
   endfunction : is_two_wire

   assign pinMap = crossbar_map(st.skip, st.perEn);

   ////////////////////////////////////////////////////////////////////////////
   // Register file and synchronisers

   always_comb
   begin
      next_st         = st;
      next_st.pinMeta = pinIn;
      next_st.pinSync = st.pinMeta;
      next_st.cmpMeta = periphOut.cmpSync;
      next_st.cmpSync = st.cmpMeta;
      next_st.rdData  = pxb_pkg::READ_IDLE;
      if (busReq.wr)
      begin
         case (busReq.addr)
            pxb_pkg::PORT_OUTPUT_DRIVE_SELECT_ADDR:   next_st.drvSel = busReq.wrData;
            pxb_pkg::CROSSBAR_PIN_SKIP_ADDR:          next_st.skip = busReq.wrData[6:0]; // [R12]
            pxb_pkg::CROSSBAR_PERIPHERAL_ENABLE_ADDR: next_st.perEn = busReq.wrData;
            pxb_pkg::PORT_INPUT_MODE_SELECT_ADDR:     next_st.inMode = busReq.wrData;
            default:                                  next_st.inMode = st.inMode;
         endcase
      end
      if (busReq.rd)
      begin
         case (busReq.addr)
            pxb_pkg::PORT_OUTPUT_DRIVE_SELECT_ADDR:   next_st.rdData = st.drvSel;
            pxb_pkg::CROSSBAR_PIN_SKIP_ADDR:          next_st.rdData = {1'b0, st.skip}; // [R12]
            pxb_pkg::CROSSBAR_PERIPHERAL_ENABLE_ADDR: next_st.rdData = st.perEn;
            pxb_pkg::PORT_PIN_LEVEL_ADDR:             next_st.rdData = st.pinSync;
            pxb_pkg::PORT_INPUT_MODE_SELECT_ADDR:     next_st.rdData = st.inMode;
            default:                                  next_st.rdData = pxb_pkg::READ_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         st.drvSel  <= pxb_pkg::DRIVE_SELECT_RESET;
         st.skip    <= pxb_pkg::PIN_SKIP_RESET;
         st.perEn   <= pxb_pkg::PERIPH_EN_RESET;
         st.inMode  <= pxb_pkg::INPUT_MODE_RESET;
         st.rdData  <= pxb_pkg::READ_IDLE;
         st.pinMeta <= pxb_pkg::PIN_SYNC_RESET;
         st.pinSync <= pxb_pkg::PIN_SYNC_RESET;
         st.cmpMeta <= 1'b0;
         st.cmpSync <= 1'b0;
      end
      else if (clkEn)
      begin
         st <= next_st;
      end
   end

   assign rdData = st.rdData;

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers

   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         case (pinMap[i])
            pxb_pkg::SEL_TX:     pinVal[i] = periphOut.tx;               // [R8]
            pxb_pkg::SEL_SDA:    pinVal[i] = periphOut.sda;              // [R6]
            pxb_pkg::SEL_SCL:    pinVal[i] = periphOut.scl;              // [R6]
            pxb_pkg::SEL_CMPS:   pinVal[i] = st.cmpSync;                 // [R4]
            pxb_pkg::SEL_CMPA:   pinVal[i] = periphOut.cmpAsync;         // [R3]
            pxb_pkg::SEL_SYSCLK: pinVal[i] = mclk;                       // [R5]
            pxb_pkg::SEL_ARR0:   pinVal[i] = periphOut.arrayOut[0];      // [R2]
            pxb_pkg::SEL_ARR1:   pinVal[i] = periphOut.arrayOut[1];      // [R2]
            pxb_pkg::SEL_ARR2:   pinVal[i] = periphOut.arrayOut[2];      // [R2]
            default:             pinVal[i] = 1'b1;
         endcase
         // Analog pins are never driven, so their drive bit is moot
         pinDrive[i] = st.inMode[i] && (pinMap[i] != pxb_pkg::SEL_NONE)
                       && (pinMap[i] != pxb_pkg::SEL_RX);              // [R10]
         pinOd[i]    = !st.drvSel[i] || is_two_wire(pinMap[i]);        // [R9] [R11]
         pinOut[i]   = pinOd[i] ? 1'b0 : pinVal[i];
         pinOe[i]    = pinDrive[i] && (pinOd[i] ? !pinVal[i] : 1'b1);   // [R9]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Peripheral inputs, idle high when not routed

   always_comb
   begin
      periphIn.rx  = st.perEn[pxb_pkg::SERIAL_RX_PIN_ENABLE_BIT]
                     ? st.pinSync[pxb_pkg::RX_PIN] : 1'b1;              // [R7]
      periphIn.sda = 1'b1;
      periphIn.scl = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         if (pinMap[i] == pxb_pkg::SEL_SDA)
         begin
            periphIn.sda = st.pinSync[i];                              // [R6]
         end
         if (pinMap[i] == pxb_pkg::SEL_SCL)
         begin
            periphIn.scl = st.pinSync[i];                              // [R6]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic [7:0] mapTx;
   logic [7:0] mapCmpA;
   logic [7:0] mapCmpS;
   logic [7:0] mapClk;
   logic [7:0] mapArr2;
   logic [7:0] mapTw;
   logic [7:0] mapAny;
   logic [7:0] mapArr0;
   logic [7:0] mapArr1;
   logic [7:0] mapSda;
   logic [7:0] mapScl;

   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         mapTx[i]   = (pinMap[i] == pxb_pkg::SEL_TX);
         mapCmpA[i] = (pinMap[i] == pxb_pkg::SEL_CMPA);
         mapCmpS[i] = (pinMap[i] == pxb_pkg::SEL_CMPS);
         mapClk[i]  = (pinMap[i] == pxb_pkg::SEL_SYSCLK);
         mapArr2[i] = (pinMap[i] == pxb_pkg::SEL_ARR2);
         mapArr0[i] = (pinMap[i] == pxb_pkg::SEL_ARR0);
         mapArr1[i] = (pinMap[i] == pxb_pkg::SEL_ARR1);
         mapSda[i]  = (pinMap[i] == pxb_pkg::SEL_SDA);
         mapScl[i]  = (pinMap[i] == pxb_pkg::SEL_SCL);
         mapTw[i]   = is_two_wire(pinMap[i]);
         mapAny[i]  = (pinMap[i] != pxb_pkg::SEL_NONE);
      end
   end

   chk_skip_pass: assert property (@(posedge mclk) disable iff (sys_rst) // [R1]
      !(|(st.skip & mapAny[6:0] & ~mapTx[6:0] & ~(7'h20 & {7{st.perEn[1]}}))))
      else $error("skipped pin carries a movable signal");

   chk_array_count: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
      (|mapArr2) |-> (st.perEn[7:6] == 2'h3))
      else $error("third array output routed with count below three");

   chk_async_cmp: assert property (@(posedge mclk) disable iff (sys_rst) // [R3]
      (st.perEn[5] == 1'b0) |-> (mapCmpA == 8'h00))
      else $error("async comparator routed while disabled");

   chk_sync_cmp: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
      (busReq.wr && busReq.addr == pxb_pkg::CROSSBAR_PERIPHERAL_ENABLE_ADDR
       && busReq.wrData == 8'h10 && clkEn)
      |=> (mapCmpS == 8'h01 || st.skip[0]))
      else $error("sync comparator not on lowest free pin");

   chk_sysclk_off: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
      (st.perEn[3] == 1'b0) |-> (mapClk == 8'h00))
      else $error("system clock on a pin while disabled");

   chk_rx_idle: assert property (@(posedge mclk) disable iff (sys_rst) // [R7]
      !st.perEn[1] |-> periphIn.rx)
      else $error("receive input taken while disabled");

   chk_tx_pin: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
      st.perEn[0] |-> (mapTx == 8'h10 && (!st.inMode[4] || pinOe[4] || st.drvSel[4] == 1'b0)))
      else $error("transmit not on pin 4");

   chk_push_pull: assert property (@(posedge mclk) disable iff (sys_rst) // [R9]
      (st.perEn[0] && st.drvSel[4] && st.inMode[4]) |-> (pinOe[4] && pinOut[4] == periphOut.tx))
      else $error("push-pull transmit pin not driven");

   chk_analog_off: assert property (@(posedge mclk) disable iff (sys_rst) // [R10]
      (pinOe & ~st.inMode) == 8'h00)
      else $error("analog pin driven");

   chk_two_wire_od: assert property (@(posedge mclk) disable iff (sys_rst) // [R11]
      (pinOe & pinOut & mapTw) == 8'h00)
      else $error("two-wire pin driven high");

   chk_skip_read: assert property (@(posedge mclk) disable iff (sys_rst) // [R12]
      (clkEn && busReq.rd && busReq.addr == pxb_pkg::CROSSBAR_PIN_SKIP_ADDR)
      |=> (rdData == {1'b0, $past(st.skip)}))
      else $error("skip register readback wrong");

   chk_array_none: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
      (st.perEn[pxb_pkg::ARRAY_OUTPUT_COUNT_LSB +: 2] == 2'h0)
      |-> ((mapArr0 | mapArr1 | mapArr2) == 8'h00))
      else $error("array output routed with count zero");

   chk_array_one: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
      (st.perEn[pxb_pkg::ARRAY_OUTPUT_COUNT_LSB +: 2] == 2'h1)
      |-> ((mapArr1 | mapArr2) == 8'h00))
      else $error("second or third array output routed with count one");

   chk_async_first: assert property (@(posedge mclk) disable iff (sys_rst) // [R3] [R12]
      ((st.perEn >> pxb_pkg::TWO_WIRE_PINS_ENABLE_BIT) == 8'h08 && st.skip == '0)
      |-> (mapCmpA == 8'h01))
      else $error("async comparator not on lowest pin");

   chk_sync_off: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
      !st.perEn[pxb_pkg::SYNC_COMPARATOR_OUT_ENABLE_BIT] |-> (mapCmpS == 8'h00))
      else $error("sync comparator routed while disabled");

   chk_sysclk_first: assert property (@(posedge mclk) disable iff (sys_rst) // [R5] [R12]
      ((st.perEn >> pxb_pkg::TWO_WIRE_PINS_ENABLE_BIT) == 8'h02 && st.skip == '0)
      |-> (mapClk == 8'h01))
      else $error("system clock not on lowest pin");

   chk_two_wire_off: assert property (@(posedge mclk) disable iff (sys_rst) // [R6]
      !st.perEn[pxb_pkg::TWO_WIRE_PINS_ENABLE_BIT] |-> (mapTw == 8'h00))
      else $error("two-wire signals routed while disabled");

   chk_two_wire_order: assert property (@(posedge mclk) disable iff (sys_rst) // [R6] [R12]
      (|mapSda && |mapScl) |-> (mapSda < mapScl))
      else $error("two-wire pins out of priority order");

   chk_rx_route: assert property (@(posedge mclk) disable iff (sys_rst) // [R7]
      st.perEn[pxb_pkg::SERIAL_RX_PIN_ENABLE_BIT]
      |-> (periphIn.rx == st.pinSync[pxb_pkg::RX_PIN] && !pinOe[pxb_pkg::RX_PIN]))
      else $error("receive pin not taken as input");

   chk_tx_off: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
      !st.perEn[pxb_pkg::SERIAL_TX_PIN_ENABLE_BIT] |-> (mapTx == 8'h00))
      else $error("transmit on a pin while disabled");

   chk_open_drain: assert property (@(posedge mclk) disable iff (sys_rst) // [R9]
      (st.inMode & ~st.drvSel & pinOut) == 8'h00)
      else $error("open-drain pin drives high");

   chk_skip_write: assert property (@(posedge mclk) disable iff (sys_rst) // [R1] [R12]
      (clkEn && busReq.wr && busReq.addr == pxb_pkg::CROSSBAR_PIN_SKIP_ADDR)
      |=> (st.skip == $past(busReq.wrData[6:0])))
      else $error("skip register write lost");

   chk_hold_frozen: assert property (@(posedge mclk) disable iff (sys_rst)
      !clkEn |=> ($stable(st.drvSel) && $stable(st.skip) && $stable(st.perEn)))
      else $error("configuration changed while clock enable low");

   chk_read_idle: assert property (@(posedge mclk) disable iff (sys_rst)
      (clkEn && !busReq.rd) |=> (rdData == pxb_pkg::READ_IDLE))
      else $error("read data not idle after a cycle without read");

endmodule : pxb_port_crossbar
